// >>> design/dbm_mapper.sv
// bits-and-gains encoder with medley and sync symbol mapper
`include "dbm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dbm_mapper
    import dbm_pkg::*;
#(
    parameter logic [12:0] NUM_TONES = 13'h1000 - 13'h1,
    parameter logic [7:0]  SKIP_BITS = 8'h10,
    parameter logic [22:0] LFSR_TAPS = 23'h400010,
    parameter logic [22:0] LFSR_SEED = 23'h7FFFFF
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        ent_valid,
    output logic             ent_ready,
    input  wire logic        ent_used,
    input  wire logic        ent_last,
    input  wire logic [3:0]  ent_load,
    input  wire logic [11:0] ent_count,
    input  wire logic [11:0] ent_gain,
    output logic             tone_valid,
    output logic [12:0]      tone_idx,
    output logic [1:0]       tone_point,
    output logic             sym_start,
    output logic             sym_sync,
    output logic [7:0]       cp_len,
    output logic             data_mode
);
    typedef struct packed {
        dbm_state_t  st;
        logic        ca;
        logic        dmode;
        logic        sync_req;
        logic        in_sync;
        logic [3:0]  sync_no;
        logic        rot_en;
        logic [7:0]  ord;
        logic [7:0]  max_ord;
        logic [7:0]  code;
        logic [15:0] grp_cnt;
        logic [7:0]  ce_cur;
        logic [7:0]  ce_new;
        logic        ord_err;
        logic        fmt_err;
        logic        busy;
        logic        flush;
        dbm_hdr_t    hdr;
        logic        in_gains;
        logic [7:0]  gain_no;
        logic [31:0] acc;
        logic [5:0]  fill;
        logic [7:0]  lo;
        logic        half;
        logic [15:0] pay;
        logic        pay_full;
        logic [22:0] lfsr;
        logic [7:0]  skip;
        logic [12:0] tone;
        logic [3:0]  ph10;
        logic [15:0] sym_pay;
        logic [15:0] sym_total;
        logic        t_valid;
        logic [12:0] t_idx;
        logic [1:0]  t_raw;
        logic [1:0]  t_point;
        logic        t_start;
        logic        t_sync;
        logic [31:0] rdata;
    } dbm_state_s_t;

    dbm_state_s_t s_reg;
    dbm_state_s_t s_next;

    function automatic logic [22:0] lfsr_step(input logic [22:0] v);
        lfsr_step = {v[21:0], ^(v & LFSR_TAPS)};
    endfunction

    // quadrant order of 4QAM points: 00, 01, 11, 10
    function automatic logic [1:0] rotate(input logic [1:0] p,
                                          input logic [1:0] k);
        logic [1:0] q;
        q = {p[1], p[1] ^ p[0]} + k;
        rotate = {q[1], q[1] ^ q[0]};
    endfunction

    // 16-bit payload to tone point by position within ten tones
    function automatic logic [1:0] medley_point(input logic [15:0] pay,
                                                input logic [3:0]  ph);
        case (ph)
            4'h1:    medley_point = pay[1:0];
            4'h2:    medley_point = pay[3:2];
            4'h3:    medley_point = pay[5:4];
            4'h4:    medley_point = pay[7:6];
            4'h6:    medley_point = pay[9:8];
            4'h7:    medley_point = pay[11:10];
            4'h8:    medley_point = pay[13:12];
            4'h9:    medley_point = pay[15:14];
            default: medley_point = 2'h0;
        endcase
    endfunction

    function automatic logic [31:0] place(input logic [31:0] acc,
                                          input logic [15:0] v,
                                          input logic [5:0]  fill);
        place = acc | ({16'h0000, v} << fill);
    endfunction

    logic        wr_ctrl;
    logic        enter;
    logic        msg_go;
    logic        pop;
    logic [31:0] acc_p;
    logic [5:0]  fill_p;
    logic [15:0] ent_word;
    logic [5:0]  ent_w;
    logic        ent_fire;
    logic [1:0]  rbits;
    logic [22:0] l1;
    logic [22:0] l2;
    logic        last_tone;

    assign wr_ctrl = reg_wr && reg_addr == `DBM_OFF_CTRL;
    assign enter   = wr_ctrl && reg_wdata[`DBM_CTRL_ENTER];
    // an order beyond the remote's declared maximum is refused
    assign msg_go  = wr_ctrl && reg_wdata[`DBM_CTRL_MSG] && !s_reg.busy
                     && s_reg.ord <= s_reg.max_ord;
    assign pop       = s_reg.fill >= 6'd8 && (!s_reg.half || !s_reg.pay_full);
    assign acc_p     = pop ? {8'h00, s_reg.acc[31:8]} : s_reg.acc;
    assign fill_p    = pop ? s_reg.fill - 6'd8 : s_reg.fill;
    assign ent_ready = s_reg.busy && s_reg.hdr == DBM_H_ENTRY
                       && !s_reg.flush && fill_p <= 6'd16;
    assign ent_fire  = ent_valid && ent_ready;
    assign last_tone = s_reg.tone == NUM_TONES;
    assign l1        = lfsr_step(s_reg.lfsr);
    assign l2        = lfsr_step(l1);
    assign rbits     = {l1[0], l2[0]};

    always_comb begin
        if (s_reg.ord == 8'h00) begin
            ent_word = {ent_gain, ent_load};
            ent_w    = 6'd16;
        end else if (s_reg.in_gains) begin
            ent_word = {4'h0, ent_gain};
            ent_w    = 6'd12;
        end else if (s_reg.ord[0]) begin
            ent_word = {ent_count, ent_load};
            ent_w    = 6'd16;
        end else begin
            ent_word = {4'h0, ent_count[7:0], ent_load};
            ent_w    = 6'd12;
        end
    end

    always_comb begin
        s_next         = s_reg;
        s_next.acc     = acc_p;
        s_next.fill    = fill_p;
        s_next.t_valid = 1'b0;
        s_next.t_start = 1'b0;
        s_next.rdata   = 32'h0000_0000;

        if (reg_wr) begin
            case (reg_addr)
                `DBM_OFF_ORDER:   s_next.ord = reg_wdata[7:0];
                `DBM_OFF_MAXORD:  s_next.max_ord = reg_wdata[7:0];
                `DBM_OFF_MSGCODE: s_next.code = reg_wdata[7:0];
                `DBM_OFF_GRPCNT:  s_next.grp_cnt = reg_wdata[15:0];
                `DBM_OFF_CE:      s_next.ce_new = reg_wdata[7:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `DBM_OFF_ORDER:   s_next.rdata = {24'h0, s_reg.ord};
                `DBM_OFF_MAXORD:  s_next.rdata = {24'h0, s_reg.max_ord};
                `DBM_OFF_MSGCODE: s_next.rdata = {24'h0, s_reg.code};
                `DBM_OFF_GRPCNT:  s_next.rdata = {16'h0, s_reg.grp_cnt};
                `DBM_OFF_CE:      s_next.rdata = {24'h0, s_reg.ce_new};
                `DBM_OFF_STATUS:  s_next.rdata = {26'h0, s_reg.ca,
                                    s_reg.in_sync, s_reg.fmt_err,
                                    s_reg.ord_err, s_reg.dmode, s_reg.busy};
                `DBM_OFF_SYMCNT:  s_next.rdata = {16'h0, s_reg.sym_total};
                default:          s_next.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_ctrl && reg_wdata[`DBM_CTRL_MSG] && !msg_go && !s_reg.busy)
            s_next.ord_err = 1'b1;
        if (msg_go) begin
            s_next.busy     = 1'b1;
            s_next.hdr      = DBM_H_CODE;
            s_next.in_gains = 1'b0;
            s_next.flush    = 1'b0;
            s_next.ord_err  = 1'b0;
            s_next.fmt_err  = 1'b0;
        end
        if (wr_ctrl && reg_wdata[`DBM_CTRL_SYNC] && s_reg.ca)
            s_next.sync_req = 1'b1;

        // header fields of the message, one per cycle while room
        if (s_reg.busy && fill_p <= 6'd16) begin
            case (s_reg.hdr)
                DBM_H_CODE: begin
                    s_next.acc  = place(acc_p, {8'h00, s_reg.code}, fill_p);
                    s_next.fill = fill_p + 6'd8;
                    s_next.hdr  = DBM_H_ORDER;
                end
                DBM_H_ORDER: begin
                    s_next.acc  = place(acc_p, {8'h00, s_reg.ord}, fill_p);
                    s_next.fill = fill_p + 6'd8;
                    s_next.hdr  = s_reg.ord == 8'h00 ? DBM_H_ENTRY
                                                      : DBM_H_COUNT;
                end
                DBM_H_COUNT: begin
                    s_next.acc  = place(acc_p, s_reg.grp_cnt, fill_p);
                    s_next.fill = fill_p + 6'd16;
                    s_next.hdr  = DBM_H_ENTRY;
                end
                default: ;
            endcase
        end

        // in order 0, unused tones are taken without encoding anything; other orders encode every entry
        if (ent_fire) begin
            if (ent_used || s_reg.ord != 8'h00) begin
                s_next.acc  = place(acc_p, ent_word & ((16'h1 << ent_w)
                                    - 16'h1), fill_p);
                s_next.fill = fill_p + ent_w;
            end
            if (s_reg.ord != 8'h00 && !s_reg.in_gains) begin
                if (ent_count > `DBM_GROUP_MAX || ent_count == 12'h000)
                    s_next.fmt_err = 1'b1;
                s_next.in_gains = 1'b1;
                s_next.gain_no  = 8'h00;
            end else if (s_reg.in_gains) begin
                s_next.gain_no = s_reg.gain_no + 8'h01;
                if (s_reg.gain_no == s_reg.ord)
                    s_next.in_gains = 1'b0;
            end
            // early stop: trailing zero-load tones are simply never sent
            if (ent_last)
                s_next.flush = 1'b1;
        end
        if (s_reg.flush && s_reg.fill != 6'd0 && s_reg.fill < 6'd8 && !pop)
            s_next.fill = 6'd8;
        if (s_reg.flush && s_reg.fill == 6'd0) begin
            if (s_reg.half && !s_reg.pay_full) begin
                s_next.pay      = {8'h00, s_reg.lo};
                s_next.pay_full = 1'b1;
                s_next.half     = 1'b0;
            end else if (!s_reg.half) begin
                s_next.busy  = 1'b0;
                s_next.flush = 1'b0;
            end
        end

        // byte pairing into the payload holding register
        if (pop) begin
            if (!s_reg.half) begin
                s_next.lo   = s_reg.acc[7:0];
                s_next.half = 1'b1;
            end else begin
                s_next.pay      = {s_reg.acc[7:0], s_reg.lo};
                s_next.pay_full = 1'b1;
                s_next.half     = 1'b0;
            end
        end

        // symbol engine
        case (s_reg.st)
            DBM_IDLE: begin
                if (s_reg.ca && !s_reg.dmode) begin
                    s_next.st   = DBM_SYM;
                    s_next.tone = 13'h0000;
                    s_next.ph10 = 4'h0;
                end
            end
            DBM_SKIP: begin
                s_next.lfsr = l1;
                s_next.skip = s_reg.skip - 8'h01;
                if (s_reg.skip <= 8'h01) begin
                    s_next.st = s_reg.dmode ? DBM_IDLE : DBM_SYM;
                    s_next.tone = 13'h0000;
                    s_next.ph10 = 4'h0;
                end
            end
            DBM_SYM: begin
                if (s_reg.tone == 13'h0000) begin
                    s_next.t_start = 1'b1;
                    s_next.sym_total = s_reg.sym_total + 16'h0001;
                    if (s_reg.in_sync && s_reg.sync_no == `DBM_SYNC_SYMS) begin
                        s_next.in_sync = 1'b0;
                        s_next.dmode   = 1'b1;
                        s_next.rot_en  = 1'b0;
                        s_next.ce_cur  = s_reg.ce_new;
                        s_next.t_start = 1'b0;
                        s_next.st      = DBM_IDLE;
                    end else if (s_reg.in_sync) begin
                        s_next.sync_no = s_reg.sync_no + 4'h1;
                    end else if (s_reg.sync_req) begin
                        s_next.in_sync  = 1'b1;
                        s_next.sync_req = 1'b0;
                        s_next.sync_no  = 4'h1;
                    end
                    if (!s_reg.in_sync && !s_reg.sync_req) begin
                        s_next.sym_pay  = s_next.pay_full ? s_next.pay
                                                         : 16'h0000;
                        s_next.pay_full = 1'b0;
                    end
                end
                if (s_next.st == DBM_SYM) begin
                    // two generator bits are spent per tone, DC too
                    s_next.lfsr    = l2;
                    s_next.t_valid = 1'b1;
                    s_next.t_idx   = s_reg.tone;
                    s_next.t_sync  = s_next.in_sync;
                    if (s_next.in_sync)
                        s_next.t_raw = (s_next.sync_no >= `DBM_SYNC_ZERO_LO
                                     && s_next.sync_no <= `DBM_SYNC_ZERO_HI)
                                     ? 2'b00 : 2'b11;
                    else
                        s_next.t_raw = medley_point(s_next.sym_pay,
                                                    s_reg.ph10);
                    s_next.t_point = s_reg.rot_en
                                     ? rotate(s_next.t_raw, rbits)
                                     : s_next.t_raw;
                    s_next.tone = s_reg.tone + 13'h0001;
                    s_next.ph10 = s_reg.ph10 == 4'h9 ? 4'h0
                                                     : s_reg.ph10 + 4'h1;
                    if (last_tone) begin
                        s_next.st   = DBM_SKIP;
                        s_next.skip = SKIP_BITS;
                        if (SKIP_BITS == 8'h00)
                            s_next.st = DBM_SYM;
                        s_next.tone = 13'h0000;
                        s_next.ph10 = 4'h0;
                    end
                end
            end
            default: s_next.st = DBM_IDLE;
        endcase

        // apart from reset, entering channel analysis is the one place the scrambler restarts
        if (enter) begin
            s_next.lfsr      = LFSR_SEED;
            s_next.ca        = 1'b1;
            s_next.dmode     = 1'b0;
            s_next.rot_en    = 1'b1;
            s_next.in_sync   = 1'b0;
            s_next.sync_req  = 1'b0;
            s_next.st        = DBM_IDLE;
            s_next.sym_total = 16'h0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg        <= '0;
            s_reg.st     <= DBM_IDLE;
            s_reg.hdr    <= DBM_H_CODE;
            s_reg.lfsr   <= LFSR_SEED;
            s_reg.ce_cur <= `DBM_CE_RESET;
            s_reg.ce_new <= `DBM_CE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata  = s_reg.rdata;
    assign tone_valid = s_reg.t_valid;
    assign tone_idx   = s_reg.t_idx;
    assign tone_point = s_reg.t_point;
    assign sym_start  = s_reg.t_start;
    assign sym_sync   = s_reg.t_sync;
    assign cp_len     = s_reg.ce_cur;
    assign data_mode  = s_reg.dmode;

    property p_scr_reset;
        @(posedge core_clk) disable iff (!rst_n)
        enter |=> s_reg.lfsr == LFSR_SEED;
    endproperty
    a_scr_reset: assert property (p_scr_reset)
        else $error("scrambler not reseeded on entering analysis");

    property p_rot_off;
        @(posedge core_clk) disable iff (!rst_n)
        (s_reg.dmode && !enter) |=> !s_reg.rot_en && s_reg.dmode;
    endproperty
    a_rot_off: assert property (p_rot_off)
        else $error("rotation active in data mode");

    property p_med_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (s_reg.t_valid && !s_reg.t_sync && s_reg.t_idx % 13'd5 == 13'd0)
            |-> s_reg.t_raw == 2'b00;
    endproperty
    a_med_zero: assert property (p_med_zero)
        else $error("multiple-of-five tone not zero");

    property p_sync_pat;
        @(posedge core_clk) disable iff (!rst_n)
        (s_reg.t_valid && s_reg.t_sync) |-> s_reg.t_raw ==
            ((s_reg.sync_no >= 4'h6 && s_reg.sync_no <= 4'hA) ? 2'b00
                                                               : 2'b11);
    endproperty
    a_sync_pat: assert property (p_sync_pat)
        else $error("wrong sync constellation point");

    property p_skip;
        @(posedge core_clk) disable iff (!rst_n)
        (s_reg.st == DBM_SYM && last_tone && !enter && SKIP_BITS > 8'h01)
            |=> s_reg.st == DBM_SKIP ##1 s_reg.st == DBM_SKIP;
    endproperty
    a_skip: assert property (p_skip)
        else $error("generator bits not skipped between symbols");

    property p_order;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(s_reg.busy) |-> $past(s_reg.ord) <= $past(s_reg.max_ord);
    endproperty
    a_order: assert property (p_order)
        else $error("order above remote capability accepted");

    property p_pair;
        @(posedge core_clk) disable iff (!rst_n)
        (pop && s_reg.half) |=> s_reg.pay[7:0] == $past(s_reg.lo);
    endproperty
    a_pair: assert property (p_pair)
        else $error("payload byte order wrong");

    property p_ce;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(s_reg.dmode) |-> s_reg.ce_cur == $past(s_reg.ce_new)
            && $past(s_reg.sync_no) == 4'hF;
    endproperty
    a_ce: assert property (p_ce)
        else $error("prefix or data mode change not at sync end");

    c_sync_done: cover property (@(posedge core_clk) $rose(s_reg.dmode));
    c_msg_done:  cover property (@(posedge core_clk) $fell(s_reg.busy));
    c_ord_err:   cover property (@(posedge core_clk) $rose(s_reg.ord_err));
endmodule
`default_nettype wire

// >>> design/dbm_defines.svh
// constants for the bits-and-gains encoder and medley/sync symbol mapper
`ifndef DBM_DEFINES_SVH
`define DBM_DEFINES_SVH
`define DBM_OFF_CTRL      4'h0
`define DBM_OFF_ORDER     4'h1
`define DBM_OFF_MAXORD    4'h2
`define DBM_OFF_MSGCODE   4'h3
`define DBM_OFF_GRPCNT    4'h4
`define DBM_OFF_CE        4'h5
`define DBM_OFF_STATUS    4'h6
`define DBM_OFF_SYMCNT    4'h7
`define DBM_CTRL_ENTER    0
`define DBM_CTRL_MSG      1
`define DBM_CTRL_SYNC     2
`define DBM_ST_BUSY       0
`define DBM_ST_DATA       1
`define DBM_ST_ORDERR     2
`define DBM_ST_FMTERR     3
`define DBM_ST_SYNC       4
`define DBM_ST_CA         5
`define DBM_SYNC_SYMS     4'hF
`define DBM_SYNC_ZERO_LO  4'h6
`define DBM_SYNC_ZERO_HI  4'hA
`define DBM_GROUP_MAX     12'h0FF
`define DBM_LFSR_W        23
`define DBM_TONE_W        13
`define DBM_CE_W          8
`define DBM_CE_RESET      8'h00
`endif

// >>> design/dbm_pkg.sv
// types shared by the bits-and-gains mapper
package dbm_pkg;
    typedef enum logic [1:0] {
        DBM_IDLE,
        DBM_SKIP,
        DBM_SYM
    } dbm_state_t;

    typedef enum logic [1:0] {
        DBM_H_CODE,
        DBM_H_ORDER,
        DBM_H_COUNT,
        DBM_H_ENTRY
    } dbm_hdr_t;
endpackage

// >>> verification/dbm_remote_rx.sv
// far-end receiver model: counts tones and sync symbols seen on the line
`timescale 1ns/100ps
`default_nettype none
module dbm_remote_rx #(
    parameter logic [7:0]  SKIP_BITS = 8'h10,
    parameter logic [22:0] LFSR_TAPS = 23'h400010,
    parameter logic [22:0] LFSR_SEED = 23'h7FFFFF
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        tone_valid,
    input  wire logic [12:0] tone_idx,
    input  wire logic [1:0]  tone_point,
    input  wire logic        sym_start,
    input  wire logic        sym_sync,
    input  wire logic        data_mode,
    output logic      [13:0] sym_tones,
    output logic      [4:0]  sync_syms,
    output logic      [7:0]  bad_idx,
    output logic      [7:0]  late_tones,
    output logic      [7:0]  bad_point
);
    logic [13:0] cur_cnt;
    logic [22:0] prbs;
    logic [22:0] base;
    logic [22:0] s1;
    logic [22:0] s2;
    logic [4:0]  syn_no;
    logic [1:0]  want;
    logic [1:0]  q;

    // receiver's own scrambler copy; assumes one entry into analysis
    function automatic logic [22:0] adv(input logic [22:0] v);
        adv = {v[21:0], ^(v & LFSR_TAPS)};
    endfunction

    always_comb begin
        base = prbs;
        // bits burnt in the gap before every symbol but the first
        if (sym_start && cur_cnt != 14'h0000) begin
            for (int i = 0; i < int'(SKIP_BITS); i++) begin
                base = adv(base);
            end
        end
        s1     = adv(base);
        s2     = adv(s1);
        syn_no = sym_start ? sync_syms + 5'h01 : sync_syms;
        want   = (sym_sync && (syn_no < 5'h06 || syn_no > 5'h0A))
                 ? 2'b11 : 2'b00;
        // undo the quadrant rotation: points run 00, 01, 11, 10
        q      = {tone_point[1], ^tone_point} - {s1[0], s2[0]};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {cur_cnt, sym_tones, sync_syms, bad_idx, late_tones} <= '0;
            bad_point <= 8'h00;
            prbs      <= LFSR_SEED;
        end else if (tone_valid) begin
            cur_cnt <= sym_start ? 14'h0001 : cur_cnt + 14'h0001;
            prbs    <= s2;
            if (sym_start && cur_cnt != 14'h0000) begin
                sym_tones <= cur_cnt;
            end
            if (sym_start && sym_sync) begin
                sync_syms <= sync_syms + 5'h01;
            end
            if (tone_idx != (sym_start ? 13'h0000 : cur_cnt[12:0])) begin
                bad_idx <= bad_idx + 8'h01;
            end
            if ((sym_sync || tone_idx % 13'h0005 == 13'h0000)
                && q != {want[1], ^want}) begin
                bad_point <= bad_point + 8'h01;
            end
            // a tone after the switch means the ends disagree on data mode
            if (data_mode) begin
                late_tones <= late_tones + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/dbm_mapper_tb_top.sv
// self-checking bench for the bits-and-gains mapper
`include "dbm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dbm_mapper_tb_top;
    logic        core_clk, rst_n, reg_wr, reg_rd, ent_valid, ent_used;
    logic        ent_last, ent_ready, tone_valid, sym_start, sym_sync;
    logic        data_mode;
    logic [3:0]  reg_addr, ent_load;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [11:0] ent_count, ent_gain;
    logic [12:0] tone_idx;
    logic [1:0]  tone_point;
    logic [7:0]  cp_len, bad_idx, late_tones, bad_point;
    logic [13:0] sym_tones;
    logic [4:0]  sync_syms;
    int          err_total, samples_checked, cycles, n;

    // 20 tones a symbol keeps each symbol short
    dbm_mapper #(.NUM_TONES(13'h0013)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ent_valid(ent_valid), .ent_ready(ent_ready),
        .ent_used(ent_used), .ent_last(ent_last), .ent_load(ent_load),
        .ent_count(ent_count), .ent_gain(ent_gain), .tone_valid(tone_valid),
        .tone_idx(tone_idx), .tone_point(tone_point), .sym_start(sym_start),
        .sym_sync(sym_sync), .cp_len(cp_len), .data_mode(data_mode));
    dbm_remote_rx far (
        .core_clk(core_clk), .rst_n(rst_n), .tone_valid(tone_valid),
        .tone_idx(tone_idx), .tone_point(tone_point),
        .sym_start(sym_start), .sym_sync(sym_sync),
        .data_mode(data_mode), .sym_tones(sym_tones), .sync_syms(sync_syms),
        .bad_idx(bad_idx), .late_tones(late_tones), .bad_point(bad_point));

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdm(input logic [3:0] a, input logic [31:0] m);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rd = reg_rdata & m;
        @(posedge core_clk);
    endtask

    task automatic ent(input logic u, l, input logic [3:0] ld,
                       input logic [11:0] c, g);
        ent_valid <= 1'b1;
        {ent_used, ent_last, ent_load, ent_count, ent_gain} <= {u, l, ld, c, g};
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (ent_ready !== 1'b1 && n < 3000);
        if (n >= 3000) err_total++;
        @(posedge core_clk);
        ent_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic msg(input logic [1:0] o, input logic [11:0] c,
                       input logic [31:0] e);
        wr(`DBM_OFF_ORDER, {30'h0, o});
        wr(`DBM_OFF_GRPCNT, 32'h1);
        wr(`DBM_OFF_CTRL, 32'h2);
        if (o == 2'h0) begin
            ent(1'b1, 1'b0, 4'h2, 12'h000, 12'h200);
            ent(1'b0, 1'b0, 4'h5, 12'h000, 12'h3FF);
            // higher tones are left for the far end to take as empty
            ent(1'b1, 1'b1, 4'hF, 12'h000, 12'hFFF);
        end else begin
            // group head carries the carrier count under test
            ent(1'b1, 1'b0, 4'h3, c, 12'h000);
            for (int j = 0; j <= o; j++) begin
                ent(1'b1, j == o, 4'h3, c, 12'h100 + 12'(j));
            end
        end
        n = 0;
        do begin
            rdm(`DBM_OFF_STATUS, 32'h1);
        end while (rd !== 32'h0 && ++n < 500);
        check("busy", rd, 32'h0);
        rdm(`DBM_OFF_STATUS, 32'hC);
        check("message errors", rd, e);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, ent_valid, ent_used, ent_last} = '0;
        {reg_addr, reg_wdata, ent_load, ent_count, ent_gain} = '0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdm(`DBM_OFF_STATUS, 32'hFFFFFFFF);
        check("status after reset", rd, 32'h0);
        rdm(4'hC, 32'hFFFFFFFF);
        check("unmapped read", rd, 32'h0);
        wr(`DBM_OFF_CTRL, 32'h1);
        rdm(`DBM_OFF_STATUS, 32'h20);
        check("analysis flag", rd, 32'h20);
        repeat (100) @(posedge core_clk);
        check("tones per symbol", 32'(sym_tones), 32'h14);
        check("tone order", 32'(bad_idx), 32'h0);
        wr(`DBM_OFF_MSGCODE, 32'h5A);
        wr(`DBM_OFF_MAXORD, 32'h3);
        for (int k = 0; k < 4; k++) msg(2'(k), 12'h0FF, 32'h0);
        // a group one carrier too long is flagged
        msg(2'h1, 12'h100, 32'h8);
        wr(`DBM_OFF_MAXORD, 32'h1);
        wr(`DBM_OFF_ORDER, 32'h2);
        wr(`DBM_OFF_CTRL, 32'h2);
        rdm(`DBM_OFF_STATUS, 32'h4);
        check("order above capability", rd, 32'h4);
        wr(`DBM_OFF_CE, 32'h20);
        check("early prefix change", 32'(cp_len), 32'h0);
        wr(`DBM_OFF_CTRL, 32'h4);
        n = 0;
        while (data_mode !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        check("sync symbols", 32'(sync_syms), 32'hF);
        check("rotated points", 32'(bad_point), 32'h0);
        check("new prefix", 32'(cp_len), 32'h20);
        repeat (50) @(posedge core_clk);
        check("tones in data mode", 32'(late_tones), 32'h0);
        rdm(`DBM_OFF_STATUS, 32'h2);
        check("data mode flag", rd, 32'h2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
